// ===== logic/clk_sel_pkg.sv
// Package: constants and carrier types for the clock select and sync gate block
package clk_sel_pkg;
   localparam int    NUM_PAIRS   = 4;
   localparam int    SYNC_STAGES = 3;
   localparam logic  SEL_A       = 1'b0;
   localparam logic  SEL_B       = 1'b1;
   localparam logic  SEL_DEFAULT = 1'b0;
   localparam logic  EN_DEFAULT  = 1'b1;
   localparam logic  CLK_DEFAULT = 1'b0;

   // Control pins; the _cn bits say whether a pin is driven at all
   typedef struct packed {
      logic source_select;
      logic source_select_cn;
      logic output_enable_sync;
      logic output_enable_sync_cn;
   } ctrl_pins_t;

   typedef struct packed {
      logic clock_input_a;
      logic clock_input_a_cn;
      logic clock_input_b;
      logic clock_input_b_cn;
   } clk_pins_t;

   typedef struct packed {
      logic [3:0] true_diff_outputs;
      logic [3:0] complement_diff_outputs;
   } diff_out_t;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_ROSE  = 3'b010,
      ST_APPLY = 3'b100
   } gate_state_t;
endpackage : clk_sel_pkg

// ===== logic/clock_select_sync_gate.sv
// Module: two-to-one clock selector with enable gated on whole cycles, four diff pairs
//
// Function
// - Source select low routes clock_input_a, high routes clock_input_b.
// - Four pairs carry the chosen clock; true follows, complement inverts.
// - Enabled outputs toggle; disabled hold true low and complement high.
// - After enable falls, keep toggling through one rise then one fall.
// - Any enable change applies only after a rising and a falling edge.
// - An unconnected clock input reads as constant low.
// - An unconnected source select reads low, picking clock_input_a.
// - An unconnected enable input reads high, outputs enabled.
`timescale 1ns/10ps
module clock_select_sync_gate
   import clk_sel_pkg::*;
#(
   parameter int N_PAIRS = NUM_PAIRS
) (
   input  wire logic                   mclk,
   input  wire logic                   nrst,
   input  wire clk_sel_pkg::clk_pins_t clk_pins,
   input  wire clk_sel_pkg::ctrl_pins_t ctrl_pins,
   output      clk_sel_pkg::diff_out_t diff_out
);
   import clk_sel_pkg::*;

   // ===================================================
   // Pin defaults for floating inputs
   // ===================================================
   logic clk_a_pin;
   logic clk_b_pin;
   logic sel_pin;
   logic en_pin;

   assign clk_a_pin = clk_pins.clock_input_a_cn ? clk_pins.clock_input_a : CLK_DEFAULT;
   assign clk_b_pin = clk_pins.clock_input_b_cn ? clk_pins.clock_input_b : CLK_DEFAULT;
   assign sel_pin   = ctrl_pins.source_select_cn ? ctrl_pins.source_select : SEL_DEFAULT;
   assign en_pin    = ctrl_pins.output_enable_sync_cn ?
                      ctrl_pins.output_enable_sync : EN_DEFAULT;

   // ===================================================
   // Synchronisers: three stages, change taken when stages 2 and 3 agree
   // ===================================================
   logic [SYNC_STAGES-1:0] clk_a_sync_r;
   logic [SYNC_STAGES-1:0] clk_b_sync_r;
   logic [SYNC_STAGES-1:0] sel_sync_r;
   logic [SYNC_STAGES-1:0] en_sync_r;

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         clk_a_sync_r <= {SYNC_STAGES{CLK_DEFAULT}};
         clk_b_sync_r <= {SYNC_STAGES{CLK_DEFAULT}};
         sel_sync_r   <= {SYNC_STAGES{SEL_DEFAULT}};
         en_sync_r    <= {SYNC_STAGES{EN_DEFAULT}};
      end else begin
         clk_a_sync_r <= {clk_a_sync_r[SYNC_STAGES-2:0], clk_a_pin};
         clk_b_sync_r <= {clk_b_sync_r[SYNC_STAGES-2:0], clk_b_pin};
         sel_sync_r   <= {sel_sync_r[SYNC_STAGES-2:0], sel_pin};
         en_sync_r    <= {en_sync_r[SYNC_STAGES-2:0], en_pin};
      end
   end

   // Holds the settled level while the last two stages disagree
   function automatic logic agreed(input logic [SYNC_STAGES-1:0] s, input logic held);
      agreed = (s[SYNC_STAGES-2] == s[SYNC_STAGES-1]) ? s[SYNC_STAGES-1] : held;
   endfunction : agreed

   logic clk_a_r;
   logic clk_b_r;
   logic sel_r;
   logic en_req_r;

   // Reset levels match what floating pins would read
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         clk_a_r  <= CLK_DEFAULT;
         clk_b_r  <= CLK_DEFAULT;
         sel_r    <= SEL_DEFAULT;
         en_req_r <= EN_DEFAULT;
      end else begin
         clk_a_r  <= agreed(clk_a_sync_r, clk_a_r);
         clk_b_r  <= agreed(clk_b_sync_r, clk_b_r);
         sel_r    <= agreed(sel_sync_r, sel_r);
         en_req_r <= agreed(en_sync_r, en_req_r);
      end
   end

   // ===================================================
   // Source mux; glitch-free switching is the controller's job
   // ===================================================
   logic sel_clk;
   assign sel_clk = (sel_r == SEL_B) ? clk_b_r : clk_a_r;

   // Resets low, the idle level of a floating clock, so no false edge
   logic sel_clk_d_r;
   always_ff @(posedge mclk) begin
      if (!nrst) sel_clk_d_r <= CLK_DEFAULT;
      else       sel_clk_d_r <= sel_clk;
   end

   // Edges of the sampled clock; phases under two cycles are lost
   logic rise;
   logic fall;
   assign rise = sel_clk & ~sel_clk_d_r;
   assign fall = ~sel_clk & sel_clk_d_r;

   // ===================================================
   // Enable gate: pending change waits for rise then fall
   // ===================================================
   gate_state_t state_r;
   logic        en_act_r;

   // Starts enabled, as a floating enable pin would leave it
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         state_r  <= ST_IDLE;
         en_act_r <= EN_DEFAULT;
      end else begin
         unique case (state_r)
            ST_IDLE: begin
               if (en_req_r != en_act_r) state_r <= ST_ROSE;
            end
            ST_ROSE: begin
               // Waiting for the rise; request withdrawn cancels
               if (en_req_r == en_act_r) state_r <= ST_IDLE;
               else if (rise)            state_r <= ST_APPLY;
            end
            ST_APPLY: begin
               // Applied on the fall, so the last high pulse is whole
               if (en_req_r == en_act_r) state_r <= ST_IDLE;
               else if (fall) begin
                  en_act_r <= en_req_r;
                  state_r  <= ST_IDLE;
               end
            end
         endcase
      end
   end

   // ===================================================
   // Output pairs
   // ===================================================
   // Gate ahead of the register so each pair leaves a flip-flop
   logic gated;
   assign gated = en_act_r & sel_clk;

   // Five edges of latency traded for clean sampling of the pins
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         diff_out.true_diff_outputs       <= '0;
         diff_out.complement_diff_outputs <= '1;
      end else begin
         diff_out.true_diff_outputs       <= {N_PAIRS{gated}};
         diff_out.complement_diff_outputs <= {N_PAIRS{~gated}};
      end
   end

   // ===================================================
   // Checks
   // ===================================================
   AST_PAIRS_COMPLEMENT: assert property (@(posedge mclk) disable iff (!nrst)
      diff_out.complement_diff_outputs == ~diff_out.true_diff_outputs)
      else $error("complement outputs not inverse of true outputs");

   AST_DISABLED_LOW: assert property (@(posedge mclk) disable iff (!nrst)
      !en_act_r |=> diff_out.true_diff_outputs == '0)
      else $error("true outputs not low while disabled");

   AST_ENABLED_FOLLOW: assert property (@(posedge mclk) disable iff (!nrst)
      en_act_r && sel_r == SEL_A |=> diff_out.true_diff_outputs == {N_PAIRS{$past(clk_a_r)}})
      else $error("outputs do not follow clock a");

   AST_ENABLED_FOLLOW_B: assert property (@(posedge mclk) disable iff (!nrst)
      en_act_r && sel_r == SEL_B |=> diff_out.true_diff_outputs == {N_PAIRS{$past(clk_b_r)}})
      else $error("outputs do not follow clock b");

   AST_CHANGE_ON_FALL: assert property (@(posedge mclk) disable iff (!nrst)
      $changed(en_act_r) |-> $past(fall) && $past(state_r) == ST_APPLY)
      else $error("enable changed without rise then fall");

   AST_NO_CHANGE_IDLE: assert property (@(posedge mclk) disable iff (!nrst)
      state_r == ST_IDLE && en_req_r != en_act_r |=> en_act_r == $past(en_act_r))
      else $error("enable applied before any edge");

   // Pin defaults are combinational, so they hold on the same edge
   AST_FLOAT_EN: assert property (@(posedge mclk) disable iff (!nrst)
      !ctrl_pins.output_enable_sync_cn |-> en_pin)
      else $error("floating enable not read high");

   AST_FLOAT_SEL: assert property (@(posedge mclk) disable iff (!nrst)
      !ctrl_pins.source_select_cn |-> !sel_pin)
      else $error("floating select not read low");

   AST_FLOAT_CLK: assert property (@(posedge mclk) disable iff (!nrst)
      !clk_pins.clock_input_a_cn |-> !clk_a_pin)
      else $error("floating clock a not read low");

   AST_FLOAT_CLK_B: assert property (@(posedge mclk) disable iff (!nrst)
      !clk_pins.clock_input_b_cn |-> !clk_b_pin)
      else $error("floating clock b not read low");

   // Edge ordering of the enable gate, its state encoding and the held disabled level
   AST_DISABLE_ON_LOW: assert property (@(posedge mclk) disable iff (!nrst)
      $fell(en_act_r) |-> !$past(sel_clk))
      else $error("disable applied while selected clock high");

   AST_ENABLE_ON_LOW: assert property (@(posedge mclk) disable iff (!nrst)
      $rose(en_act_r) |-> !$past(sel_clk))
      else $error("enable applied while selected clock high");

   AST_WAIT_RISE: assert property (@(posedge mclk) disable iff (!nrst)
      state_r == ST_ROSE && !rise && en_req_r != en_act_r |=>
         state_r == ST_ROSE && $stable(en_act_r))
      else $error("pending change moved on without a rise");

   AST_STATE_ONEHOT: assert property (@(posedge mclk) disable iff (!nrst)
      $onehot(state_r))
      else $error("gate state not one-hot");

   AST_HELD_DISABLED: assert property (@(posedge mclk) disable iff (!nrst)
      !$past(en_act_r) |-> diff_out.complement_diff_outputs == {N_PAIRS{1'b1}})
      else $error("complement outputs not high while disabled");

endmodule : clock_select_sync_gate

// ===== tb/clock_sources.sv
// Model of the two clock sources that feed the selector
`timescale 1ns/10ps
module clock_sources (
   input  wire logic                   mclk,
   input  wire logic [3:0]             half,
   input  wire logic [1:0]             conn,
   output      clk_sel_pkg::clk_pins_t pins
);
   import clk_sel_pkg::*;
   int cnt_a = 0;
   int cnt_b = 0;
   initial pins = '0;
   // ==========================================
   // Sources
   // A floating pin keeps toggling so any leak of it shows
   always @(negedge mclk) begin
      cnt_a = cnt_a + 1;
      cnt_b = cnt_b + 1;
      if (cnt_a >= half) begin
         pins.clock_input_a <= ~pins.clock_input_a;
         cnt_a = 0;
      end
      if (cnt_b >= half + 1) begin
         pins.clock_input_b <= ~pins.clock_input_b;
         cnt_b = 0;
      end
      // Connection changes only while low, so no pulse is cut short
      if (!pins.clock_input_a) pins.clock_input_a_cn <= conn[0];
      if (!pins.clock_input_b) pins.clock_input_b_cn <= conn[1];
   end
endmodule : clock_sources

// ===== tb/clock_select_sync_gate_test.sv
// Self-checking bench for the clock selector with synchronous output gate
`timescale 1ns/10ps
module clock_select_sync_gate_test;
   import clk_sel_pkg::*;
   logic        mclk        = 1'b0;
   logic        nrst        = 1'b0;
   logic [3:0]  half        = 4'h4;
   logic [1:0]  conn        = 2'b11;
   ctrl_pins_t  ctrl_pins   = '0;
   clk_pins_t   clk_pins;
   diff_out_t   diff_out;
   int          num_errors  = 0;
   int          check_count = 0;
   int          skip        = 48;
   int          run         = 0;
   int          since       = 0;
   logic [4:0]  hist        = '0;
   logic        en_m;
   logic        sel_m;
   logic        src_m;
   logic [31:0] seed        = 32'h5ea9614c;
   // Select only moves while disabled
   logic [5:0]  steps [8]   = '{6'h1f, 6'h17, 6'h37, 6'h3f, 6'h37, 6'h27, 6'h23, 6'h22};

   clock_select_sync_gate clock_select_sync_gate_i (.mclk(mclk), .nrst(nrst),
      .clk_pins(clk_pins), .ctrl_pins(ctrl_pins), .diff_out(diff_out));
   clock_sources clock_sources_i (.mclk(mclk), .half(half), .conn(conn), .pins(clk_pins));

   initial forever #20 mclk = ~mclk;

   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check

   task automatic print_verdict();
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : print_verdict

   // ==========================================
   // Reference model
   always_comb begin
      sel_m = ctrl_pins.source_select_cn & ctrl_pins.source_select;
      en_m  = ~ctrl_pins.output_enable_sync_cn | ctrl_pins.output_enable_sync;
      src_m = sel_m ? clk_pins.clock_input_b & clk_pins.clock_input_b_cn
                    : clk_pins.clock_input_a & clk_pins.clock_input_a_cn;
   end

   always @(posedge mclk) hist <= {hist[3:0], src_m};

   // Exact compare only once an enable change has had time to settle
   always @(negedge mclk) begin
      since = nrst ? since + 1 : 0;
      if (skip > 0) skip--;
      else check(diff_out, {{4{hist[4] & en_m}}, ~{4{hist[4] & en_m}}});
      check({4'h0, diff_out.complement_diff_outputs},
            {4'h0, ~{4{diff_out.true_diff_outputs[0]}}});
      if (diff_out.true_diff_outputs[0] === 1'b1) run++;
      else if (run != 0) begin
         // A pulse begun in the pipeline right after reset may be cut short
         if (since - run > 5) check(8'(run), 8'(half) + 8'(sel_m));
         run = 0;
      end
   end

   // ==========================================
   // Stimulus
   initial begin
      half = 4'(3 + xs() % 4);
      repeat (20) @(negedge mclk);
      nrst <= 1'b1;
      foreach (steps[i]) begin
         ctrl_pins <= steps[i][5:2];
         conn      <= steps[i][1:0];
         skip      <= 48;
         repeat (150) @(negedge mclk);
         $display("step %0d done, errors %0d", i, num_errors);
      end
      print_verdict();
   end

   initial begin
      #80000;
      num_errors++;
      print_verdict();
   end
endmodule : clock_select_sync_gate_test
